// ---- opc_master.sv ----
`timescale 1ns/1ns
module opc_master (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic bit_io(input logic b, output logic r);
        wt(2);
        sda_m = b;
        wt(3);
        scl = 1'b1;
        wt(5);
        r = sda;
        scl = 1'b0;
    endtask
    task automatic start();
        sda_m = 1'b1;
        wt(5);
        scl = 1'b1;
        wt(5);
        sda_m = 1'b0;
        wt(5);
        scl = 1'b0;
    endtask
    task automatic stop();
        wt(2);
        sda_m = 1'b0;
        wt(3);
        scl = 1'b1;
        wt(5);
        sda_m = 1'b1;
        wt(5);
    endtask
    task automatic byte_io(input logic [7:0] t, input logic ao,
                           output logic [7:0] r, output logic ai);
        for (int i = 7; i >= 0; i--) bit_io(t[i], r[i]);
        bit_io(ao, ai);
    endtask
    task automatic xfer(input logic [6:0] dev, input logic [7:0] p,
                        input logic rd, ref logic [15:0] q[$],
                        output logic nak);
        logic [7:0] h, l;
        logic       a;
        start();
        byte_io({dev, 1'b0}, 1'b1, h, nak);
        byte_io(p, 1'b1, h, a);
        if (rd) begin
            start();
            byte_io({dev, 1'b1}, 1'b1, h, a);
        end
        foreach (q[i]) begin
            byte_io(rd ? 8'hff : q[i][15:8], !rd, h, a);
            byte_io(rd ? 8'hff : q[i][7:0], !rd, l, a);
            if (rd) q[i] = {h, l};
        end
        // slave keeps sending after the last ack, clock that byte out
        if (rd) begin
            for (int k = 0; k < 8; k++) bit_io(1'b1, a);
        end
        stop();
    endtask
endmodule

// ---- opc_pkg.sv ----
package opc_pkg;

    // register map
    localparam logic [7:0]  OPC_REG_LOWER      = 8'h00;
    localparam logic [7:0]  OPC_REG_UPPER      = 8'h01;
    localparam logic [7:0]  OPC_REG_PULL       = 8'h02;

    // field layout
    localparam int          OPC_OE_BIT         = 10;
    localparam int          OPC_UPPER_MSB      = 9;
    localparam int          OPC_PULL_MSB       = 3;
    localparam int          OPC_LOWER_W        = 16;
    localparam int          OPC_UPPER_W        = 10;
    localparam int          OPC_WORD_W         = 26;
    localparam int          OPC_PULL_W         = 4;

    // reset values
    localparam logic [15:0] OPC_LOWER_RST      = 16'h0000;
    localparam logic [9:0]  OPC_UPPER_RST      = 10'h000;
    localparam logic        OPC_OE_RST         = 1'b0;
    localparam logic [3:0]  OPC_PULL_RST       = 4'h0;
    localparam logic [7:0]  OPC_PTR_RST        = 8'h00;

    // slave address, value arbitrary
    localparam logic [6:0]  OPC_DEV_ADDR       = 7'h2a;

    // serial byte timing
    localparam logic [3:0]  OPC_RX_BITS        = 4'h8;
    localparam logic [3:0]  OPC_TX_LAST        = 4'h7;

    // bus rate and sampling clock
    localparam int          OPC_CLK_PERIOD_NS  = 100;
    localparam int          OPC_BIT_PERIOD_NS  = 1000;
    localparam int          OPC_BIT_PERIOD_CYC =
        OPC_BIT_PERIOD_NS / OPC_CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        OPC_IDLE    = 3'b000,
        OPC_RX      = 3'b001,
        OPC_ACK_OUT = 3'b010,
        OPC_TX      = 3'b011,
        OPC_ACK_IN  = 3'b100
    } opc_state_t;

    typedef enum logic [1:0] {
        OPC_PH_DEV  = 2'b00,
        OPC_PH_REG  = 2'b01,
        OPC_PH_DATA = 2'b10
    } opc_phase_t;

endpackage

// ---- opc_regs.sv ----
`timescale 1ns/1ns
// Functional notes
// R1: register 0x01 bits 15..11 read zero, writes to them ignored.
// R2: register 0x01 bit 10 is software output enable, reset 0.
// R3: software enable drives output only under software enable control.
// R4: register 0x01 bits 9..0 are upper ten bits of offset word.
// R5: whole 26-bit offset word is zero after power-up.
// R6: offset word is a signed two's complement value.
// R7: new offset committed only on upper word write; lower written first.
// R8: register 0x02 bits 15..4 read zero, writes to them ignored.
// R9: register 0x02 bits 3..0 select one of sixteen pull ranges.
// R10: pull range starts from factory value, later writes overwrite it.
// R11: registers reached only via serial slave port, up to 1 Mbit/s.
// R12: register 0x00 holds lower sixteen offset bits, resets to zero.
// R13: master keeps offset updates below 38 kHz.
// R14: each register moves as two bytes, high byte first.
// R15: register pointer increments per register and wraps 255 to 0.
// R16: reads return last written value or reset value.
module opc_regs
    import opc_pkg::*;
(
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    input  wire logic                           clk_en,
    input  wire logic                           scl_in,
    input  wire logic                           sda_in,
    output logic                                sda_out,
    output logic                                sda_oe_n,
    input  wire logic                           oe_pin,
    input  wire logic                           oe_hw_strap,
    input  wire logic [opc_pkg::OPC_PULL_W-1:0] pull_strap,
    output logic signed [opc_pkg::OPC_WORD_W-1:0] freq_offset_word,
    output logic                                freq_update,
    output logic [opc_pkg::OPC_PULL_W-1:0]      pull_range,
    output logic                                output_enable
);
    import opc_pkg::*;

    opc_state_t          state;
    opc_state_t          next_state;
    opc_phase_t          phase;
    opc_phase_t          next_phase;
    logic [3:0]          bit_cnt;
    logic [3:0]          next_bit_cnt;
    logic [7:0]          shift;
    logic [7:0]          next_shift;
    logic                sda_low;
    logic                next_sda_low;
    logic                hi_byte;
    logic                next_hi_byte;
    logic                rw;
    logic                next_rw;
    logic [7:0]          reg_ptr;
    logic [7:0]          next_reg_ptr;
    logic [7:0]          data_hi;
    logic [7:0]          next_data_hi;

    logic [1:0]          scl_sync;
    logic [1:0]          sda_sync;
    logic [1:0]          oe_sync;
    logic                scl_q;
    logic                sda_q;

    logic [15:0]         lower_offset_word;
    logic [9:0]          upper_offset_word;
    logic                sw_oe;
    logic                oe_hw_ctrl;
    logic                straps_loaded;

    // register read decode
    function automatic logic [15:0] read_word(
        input logic [7:0]  addr,
        input logic [15:0] lower,
        input logic [9:0]  upper,
        input logic        oe,
        input logic [3:0]  pull
    );
        logic [15:0] w;
        w = 16'h0000;
        case (addr)
            OPC_REG_LOWER: w = lower;
            OPC_REG_UPPER: w = {5'h00, oe, upper}; // R1
            OPC_REG_PULL:  w = {12'h000, pull}; // R8
            default:       w = 16'h0000;
        endcase
        return w;
    endfunction

    // bus event decode
    wire scl_s     = scl_sync[1];
    wire sda_s     = sda_sync[1];
    wire scl_rise  = scl_s & ~scl_q;
    wire scl_fall  = ~scl_s & scl_q;
    wire bus_start = scl_s & scl_q & sda_q & ~sda_s;
    wire bus_stop  = scl_s & scl_q & ~sda_q & sda_s;
    wire addr_hit  = (shift[7:1] == OPC_DEV_ADDR);

    wire [15:0] cur_word  = read_word(reg_ptr, lower_offset_word,
                                      upper_offset_word, sw_oe, pull_range);
    wire [15:0] next_word = read_word(next_reg_ptr, lower_offset_word,
                                      upper_offset_word, sw_oe, pull_range);
    wire [7:0]  cur_tx    = hi_byte ? cur_word[15:8] : cur_word[7:0];
    wire [7:0]  adv_tx    = next_hi_byte ? next_word[15:8] : next_word[7:0];

    wire byte_done  = (state == OPC_RX) && scl_fall
                      && (bit_cnt == OPC_RX_BITS) && !bus_start && !bus_stop;
    wire wr_strobe  = byte_done && (phase == OPC_PH_DATA)
                      && !hi_byte && !rw;
    wire [15:0] wr_word = {data_hi, shift};
    wire sel_lower  = (reg_ptr == OPC_REG_LOWER);
    wire sel_upper  = (reg_ptr == OPC_REG_UPPER);
    wire sel_pull   = (reg_ptr == OPC_REG_PULL);
    wire wr_lower   = wr_strobe && sel_lower;
    wire wr_upper   = wr_strobe && sel_upper;
    wire wr_pull    = wr_strobe && sel_pull;

    // pin synchronisers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            oe_sync  <= 2'h0;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end else if (clk_en) begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            oe_sync  <= {oe_sync[0], oe_pin};
            scl_q    <= scl_s;
            sda_q    <= sda_s;
        end
    end

    // serial slave sequencing
    always_comb begin
        next_state   = state;
        next_phase   = phase;
        next_bit_cnt = bit_cnt;
        next_shift   = shift;
        next_sda_low = sda_low;
        next_hi_byte = hi_byte;
        next_rw      = rw;
        next_reg_ptr = reg_ptr;
        next_data_hi = data_hi;
        if (bus_start) begin
            next_state   = OPC_RX;
            next_phase   = OPC_PH_DEV;
            next_bit_cnt = 4'h0;
            next_sda_low = 1'b0;
            next_hi_byte = 1'b1;
        end else if (bus_stop) begin
            next_state   = OPC_IDLE;
            next_sda_low = 1'b0;
        end else begin
            case (state)
                OPC_RX: begin
                    if (scl_rise && bit_cnt != OPC_RX_BITS) begin
                        next_shift   = {shift[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end else if (byte_done) begin
                        next_state   = OPC_ACK_OUT;
                        next_sda_low = 1'b1;
                        case (phase)
                            OPC_PH_DEV: begin
                                next_rw      = shift[0];
                                next_hi_byte = 1'b1;
                                next_phase   = shift[0] ? OPC_PH_DATA
                                                        : OPC_PH_REG;
                                if (!addr_hit) begin
                                    next_state   = OPC_IDLE;
                                    next_sda_low = 1'b0;
                                end
                            end
                            OPC_PH_REG: begin
                                next_reg_ptr = shift;
                                next_phase   = OPC_PH_DATA;
                                next_hi_byte = 1'b1;
                            end
                            default: begin
                                if (hi_byte) begin // R14
                                    next_data_hi = shift;
                                    next_hi_byte = 1'b0;
                                end else begin
                                    next_hi_byte = 1'b1;
                                    next_reg_ptr = reg_ptr + 8'h01; // R15
                                end
                            end
                        endcase
                    end
                end
                OPC_ACK_OUT: begin
                    if (scl_fall) begin
                        next_bit_cnt = 4'h0;
                        if (rw && phase == OPC_PH_DATA) begin
                            next_shift   = cur_tx;
                            next_sda_low = ~cur_tx[7];
                            next_state   = OPC_TX;
                        end else begin
                            next_sda_low = 1'b0;
                            next_state   = OPC_RX;
                        end
                    end
                end
                OPC_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt == OPC_TX_LAST) begin
                            next_sda_low = 1'b0;
                            next_state   = OPC_ACK_IN;
                        end else begin
                            next_shift   = {shift[6:0], 1'b1};
                            next_sda_low = ~shift[6];
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                OPC_ACK_IN: begin
                    if (scl_fall) begin
                        if (hi_byte) begin // R14
                            next_hi_byte = 1'b0;
                        end else begin
                            next_hi_byte = 1'b1;
                            next_reg_ptr = reg_ptr + 8'h01; // R15
                        end
                        next_shift   = adv_tx;
                        next_sda_low = ~adv_tx[7];
                        next_bit_cnt = 4'h0;
                        next_state   = OPC_TX;
                    end
                end
                default: begin
                    next_state   = OPC_IDLE;
                    next_sda_low = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state   <= OPC_IDLE;
            phase   <= OPC_PH_DEV;
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
            sda_low <= 1'b0;
            hi_byte <= 1'b1;
            rw      <= 1'b0;
            reg_ptr <= OPC_PTR_RST;
            data_hi <= 8'h00;
        end else if (clk_en) begin // R11
            state   <= next_state;
            phase   <= next_phase;
            bit_cnt <= next_bit_cnt;
            shift   <= next_shift;
            sda_low <= next_sda_low;
            hi_byte <= next_hi_byte;
            rw      <= next_rw;
            reg_ptr <= next_reg_ptr;
            data_hi <= next_data_hi;
        end
    end

    // open-drain data pin, enable low while pulling low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sda_out  <= 1'b0;
            sda_oe_n <= 1'b1;
        end else if (clk_en) begin
            sda_out  <= 1'b0;
            sda_oe_n <= ~next_sda_low;
        end
    end

    // strap capture after reset release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            straps_loaded <= 1'b0;
            oe_hw_ctrl    <= 1'b0;
        end else if (clk_en && !straps_loaded) begin
            straps_loaded <= 1'b1;
            oe_hw_ctrl    <= oe_hw_strap;
        end
    end

    // register storage
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lower_offset_word <= OPC_LOWER_RST; // R12
            upper_offset_word <= OPC_UPPER_RST; // R5
            sw_oe             <= OPC_OE_RST; // R2
        end else if (clk_en) begin
            if (wr_lower) begin
                lower_offset_word <= wr_word; // R12 R16
            end
            if (wr_upper) begin
                upper_offset_word <= wr_word[OPC_UPPER_MSB:0]; // R4 R1
            end
            if (wr_upper && !oe_hw_ctrl) begin
                sw_oe <= wr_word[OPC_OE_BIT]; // R2 R3
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pull_range <= OPC_PULL_RST;
        end else if (clk_en) begin
            if (wr_pull) begin
                pull_range <= wr_word[OPC_PULL_MSB:0]; // R9 R8
            end else if (!straps_loaded) begin
                pull_range <= pull_strap; // R10
            end
        end
    end

    // offset commit on upper word write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            freq_offset_word <= '0; // R5
            freq_update      <= 1'b0;
            output_enable    <= 1'b0;
        end else if (clk_en) begin
            freq_update <= wr_upper; // R7
            if (wr_upper) begin
                freq_offset_word <= {wr_word[OPC_UPPER_MSB:0],
                                     lower_offset_word}; // R7 R6
            end
            output_enable <= oe_hw_ctrl ? oe_sync[1] : sw_oe; // R3
        end
    end

endmodule

// ---- opc_regs_sva.sv ----
`timescale 1ns/1ns
module opc_regs_sva (
    input wire logic               clk,
    input wire logic               reset_n,
    input wire logic               clk_en,
    input wire logic               scl_in,
    input wire logic               sda_in,
    input wire logic               sda_out,
    input wire logic               sda_oe_n,
    input wire logic               oe_pin,
    input wire logic               oe_hw_strap,
    input wire logic [3:0]         pull_strap,
    input wire logic signed [25:0] freq_offset_word,
    input wire logic               freq_update,
    input wire logic [3:0]         pull_range,
    input wire logic               output_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_low; sda_out == 1'b0; endproperty
    a_low: assert property (p_low) else $error("data drive high");
    property p_pulse; freq_update |=> !freq_update; endproperty
    a_pulse: assert property (p_pulse) else $error("long update");
    property p_cause; $changed(freq_offset_word) |-> freq_update; endproperty
    a_cause: assert property (p_cause) else $error("word moved");
    property p_soft;
        !oe_hw_strap && $changed(output_enable)
            |-> freq_update || $past(freq_update);
    endproperty
    a_soft: assert property (p_soft) else $error("soft enable moved");
    property p_hw_on;
        (oe_hw_strap && oe_pin) [*6] |-> output_enable;
    endproperty
    a_hw_on: assert property (p_hw_on) else $error("pin on ignored");
    property p_hw_off;
        (oe_hw_strap && !oe_pin) [*6] |-> !output_enable;
    endproperty
    a_hw_off: assert property (p_hw_off) else $error("pin off ignored");
    property p_sda; $changed(sda_oe_n) |-> !scl_in; endproperty
    a_sda: assert property (p_sda) else $error("data moved, clock high");
    property p_hold;
        !clk_en |=> $stable(freq_offset_word) && $stable(sda_oe_n);
    endproperty
    a_hold: assert property (p_hold) else $error("state moved");
    c_upd: cover property (freq_update);
    c_ack: cover property ($fell(sda_oe_n));
    c_hw: cover property (oe_hw_strap && $rose(output_enable));
endmodule
bind opc_regs opc_regs_sva u_sva (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .oe_pin(oe_pin), .oe_hw_strap(oe_hw_strap),
    .pull_strap(pull_strap), .freq_offset_word(freq_offset_word),
    .freq_update(freq_update), .pull_range(pull_range),
    .output_enable(output_enable));

// ---- tb.sv ----
`timescale 1ns/1ns
module tb;
    import opc_pkg::*;
    logic               clk, reset_n, clk_en, oe_pin, oe_hw_strap;
    logic [3:0]         pull_strap, pull_range;
    logic               sda_out, sda_oe_n, freq_update, output_enable;
    logic               scl, sda_m, nak;
    logic signed [25:0] freq_offset_word;
    logic [7:0]         rnd;
    logic [15:0]        q[$];
    logic [15:0]        m_lo, m_up, m_pl, v;
    logic [25:0]        m_w;
    int                 n_errors, checks, n_upd, e_upd;
    wire                sda = sda_m & (sda_oe_n | sda_out);
    opc_regs dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .oe_pin(oe_pin), .oe_hw_strap(oe_hw_strap),
        .pull_strap(pull_strap), .freq_offset_word(freq_offset_word),
        .freq_update(freq_update), .pull_range(pull_range),
        .output_enable(output_enable));
    opc_master m (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(negedge clk) if (freq_update === 1'b1) n_upd++;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [15:0] exp_rd(input logic [7:0] a);
        case (a)
            OPC_REG_LOWER: return m_lo;
            OPC_REG_UPPER: return m_up;
            OPC_REG_PULL:  return m_pl;
            default:       return 16'h0000;
        endcase
    endfunction
    task automatic end_sim();
        $display("checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic nx();
        rnd = lfsr(rnd);
        v = {v[7:0], rnd};
    endtask
    task automatic rst(input logic hw);
        reset_n = 1'b0;
        oe_hw_strap = hw;
        rnd = lfsr(rnd);
        pull_strap = rnd[3:0];
        repeat (6) @(posedge clk);
        #1 reset_n = 1'b1;
        m_lo = 16'h0000;
        m_up = 16'h0000;
        m_w = 26'h0;
        m_pl = {12'h000, rnd[3:0]};
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] p);
        m.xfer(OPC_DEV_ADDR, p, 1'b0, q, nak);
        foreach (q[i]) begin
            if (8'(p + i) == OPC_REG_LOWER) m_lo = q[i];
            if (8'(p + i) == OPC_REG_PULL) m_pl = {12'h000, q[i][3:0]};
            if (8'(p + i) == OPC_REG_UPPER) begin
                m_up = {5'h00, m_up[10], q[i][9:0]};
                if (!oe_hw_strap) m_up[10] = q[i][10];
                m_w = {q[i][9:0], m_lo};
                e_upd++;
            end
        end
        chk(nak, 1'b0);
        chk(freq_offset_word[25:0], m_w);
        chk(n_upd, e_upd);
        chk(pull_range, m_pl[3:0]);
        if (!oe_hw_strap) chk(output_enable, m_up[10]);
    endtask
    task automatic rd(input logic [7:0] p, input int n);
        q = {};
        repeat (n) q.push_back(16'h0000);
        m.xfer(OPC_DEV_ADDR, p, 1'b1, q, nak);
        foreach (q[i]) chk(q[i], exp_rd(8'(p + i)));
    endtask
    task automatic wait_oe(input logic e);
        int k;
        for (k = 0; k < 10 && output_enable !== e; k++) begin
            @(posedge clk);
            #1;
        end
        chk(k < 10, 1'b1);
        if (k == 10) end_sim();
    endtask
    initial begin
        clk_en = 1'b1;
        oe_pin = 1'b0;
        rnd = 8'h53;
        v = 16'h0000;
        rst(1'b0);
        chk(freq_offset_word[25:0], 26'h0);
        chk(output_enable, 1'b0);
        rd(OPC_REG_LOWER, 3);
        nx();
        nx();
        q = {v};
        wr(OPC_REG_LOWER);
        nx();
        q = {16'hffff, v, v | 16'hfc00, v | 16'hfff0};
        wr(8'hff);
        chk(freq_offset_word < 0, m_up[9]);
        rd(8'hff, 4);
        for (int c = 0; c < 16; c++) begin
            q = {16'(c)};
            wr(OPC_REG_PULL);
        end
        q = {16'h1234};
        m.xfer(OPC_DEV_ADDR ^ 7'h01, OPC_REG_LOWER, 1'b0, q, nak);
        chk(nak, 1'b1);
        rd(OPC_REG_LOWER, 1);
        clk_en = 1'b0;
        repeat (20) @(posedge clk);
        #1 clk_en = 1'b1;
        rst(1'b1);
        chk(freq_offset_word[25:0], 26'h0);
        q = {v, 16'h0401};
        wr(OPC_REG_LOWER);
        oe_pin = 1'b1;
        wait_oe(1'b1);
        oe_pin = 1'b0;
        wait_oe(1'b0);
        rd(OPC_REG_UPPER, 1);
        end_sim();
    end
endmodule
